// ===== rtl/qcrm_host_end.sv
`default_nettype none

module qcrm_host_end
  import qcrm_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Serial link
  qcrm_link_if.host link,
  // Command port
  input wire logic start_i,
  input wire qcrm_op_t op_i,
  input wire logic [31:0] addr_i,
  input wire logic [7:0] mode_i,
  input wire logic [7:0] wdata_i,
  input wire logic addr4_i,
  // Status and results
  output logic busy_o,
  output logic done_o,
  output logic [7:0] rd_data_o,
  output logic qpi_o,
  output logic cont_rd_o,
  output logic quad_en_o
);

  // ----------------------------------------------------------------------
  // Read data synchroniser
  // ----------------------------------------------------------------------
  logic [3:0] dq_s1, dq_s2;

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      dq_s1 <= 4'hF;
      dq_s2 <= 4'hF;
    end
    else
    begin
      dq_s1 <= link.dq;
      dq_s2 <= dq_s1;
    end
  end

  // ----------------------------------------------------------------------
  // Frame sequencer
  // ----------------------------------------------------------------------
  qcrm_host_state_t state, next_state, ph;
  qcrm_op_t op, next_op;
  logic [3:0] cnt, next_cnt, div, next_div, ph_len;
  logic sclk, next_sclk, cs_n, next_cs_n;
  logic [31:0] sh, next_sh;
  logic [3:0] dq_o, next_dq_o, dq_oe, next_dq_oe;
  logic [7:0] rx, next_rx, mode, next_mode, rd_data, next_rd_data;
  logic qpi, next_qpi, cont, next_cont, qe, next_qe;
  logic addr4, next_addr4, busy, next_busy, done, next_done;
  logic [7:0] wdata, next_wdata;
  logic [31:0] addr, next_addr;
  logic tick;

  assign tick = (div == QCRM_SCLK_HALF - 4'h1);

  always_comb
  begin
    next_state = state;
    next_op = op;
    next_cnt = cnt;
    next_div = tick ? 4'h0 : div + 4'h1;
    next_sclk = sclk;
    next_cs_n = cs_n;
    next_sh = sh;
    next_rx = rx;
    next_mode = mode;
    next_rd_data = rd_data;
    next_qpi = qpi;
    next_cont = cont;
    next_qe = qe;
    next_addr4 = addr4;
    next_busy = busy;
    next_done = 1'b0;
    next_wdata = wdata;
    next_addr = addr;
    ph = state;
    case (state)
      HS_OPC, HS_WDAT: ph_len = qpi ? QCRM_QPI_BYTE_CLKS : QCRM_SPI_BYTE_CLKS;
      HS_ADDR: ph_len = addr4 ? QCRM_ADDR4_CLKS : QCRM_ADDR3_CLKS;
      HS_MODE: ph_len = QCRM_MODE_CLKS;
      HS_DUMMY: ph_len = QCRM_DUMMY_CLKS;
      HS_DATA: ph_len = QCRM_DATA_CLKS;
      HS_FF: ph_len = addr4 ? QCRM_EXIT4_CLKS : QCRM_EXIT3_CLKS;
      default: ph_len = 4'h1;
    endcase
    if (state == HS_IDLE)
    begin
      next_div = 4'h0;
      if (start_i)
      begin
        next_op = op_i;
        next_addr = addr_i;
        next_addr4 = addr4_i;
        next_wdata = wdata_i;
        // Entry is only asked for once quad enable is known to be set.
        next_mode = (mode_i == QCRM_MODE_ENTER && !qe) ?
                    QCRM_MODE_EXIT : mode_i;
        next_busy = 1'b1;
        next_cs_n = 1'b0;
        next_cnt = 4'h0;
        case (op_i)
          QOP_READ: ph = cont ? HS_ADDR : HS_OPC;
          QOP_MODE_RST: ph = HS_FF;
          default: ph = HS_OPC;
        endcase
        next_state = ph;
      end
    end
    else if (state == HS_END)
    begin
      if (tick)
      begin
        next_state = HS_IDLE;
        next_busy = 1'b0;
        next_done = 1'b1;
        case (op)
          QOP_QPI_ON: next_qpi = 1'b1;
          QOP_QPI_OFF: next_qpi = 1'b0;
          QOP_WRSR: next_qe = wdata[QCRM_QE_POS];
          QOP_MODE_RST: next_cont = 1'b0;
          QOP_READ:
          begin
            // Any other Axh byte leaves the tracked state as it was.
            if (mode == QCRM_MODE_ENTER)
              next_cont = 1'b1;
            else if (mode[7:4] != QCRM_MODE_KEEP_HI)
              next_cont = 1'b0;
          end
          default: next_cont = cont;
        endcase
      end
    end
    else if (tick && !sclk)
      next_sclk = 1'b1;
    else if (tick)
    begin
      next_sclk = 1'b0;
      next_cnt = cnt + 4'h1;
      next_sh = (state == HS_OPC || state == HS_WDAT) && !qpi ?
                {sh[30:0], 1'b0} : {sh[27:0], 4'h0};
      if (state == HS_DATA)
        next_rx = {rx[3:0], dq_s2};
      if (cnt + 4'h1 == ph_len)
      begin
        next_cnt = 4'h0;
        case (state)
          HS_OPC: ph = (op == QOP_READ) ? HS_ADDR :
                       (op == QOP_WRSR) ? HS_WDAT : HS_END;
          HS_ADDR: ph = HS_MODE;
          HS_MODE: ph = HS_DUMMY;
          HS_DUMMY: ph = HS_DATA;
          default: ph = HS_END;
        endcase
        if (state == HS_DATA)
          next_rd_data = {rx[3:0], dq_s2};
        next_state = ph;
        next_cs_n = (ph == HS_END);
      end
    end
    if (ph != state)
    begin
      case (ph)
        HS_OPC:
        begin
          case (next_op)
            QOP_QPI_ON: next_sh = {QCRM_OP_QPI_ON, 24'h00_0000};
            QOP_QPI_OFF: next_sh = {QCRM_OP_QPI_OFF, 24'h00_0000};
            QOP_WRSR: next_sh = {QCRM_OP_WRSR, 24'h00_0000};
            default: next_sh = {QCRM_OP_QREAD, 24'h00_0000};
          endcase
        end
        HS_ADDR: next_sh = next_addr4 ? next_addr : {next_addr[23:0], 8'h00};
        HS_MODE: next_sh = {next_mode, 24'h00_0000};
        HS_WDAT: next_sh = {next_wdata, 24'h00_0000};
        default: next_sh = 32'h0000_0000;
      endcase
    end
    case (next_state)
      HS_OPC, HS_WDAT:
      begin
        next_dq_o = qpi ? next_sh[31:28] : {3'b000, next_sh[31]};
        next_dq_oe = qpi ? 4'hF : 4'h1;
      end
      HS_ADDR, HS_MODE:
      begin
        next_dq_o = next_sh[31:28];
        next_dq_oe = 4'hF;
      end
      HS_FF:
      begin
        next_dq_o = QCRM_ALL_ONES;
        next_dq_oe = 4'hF;
      end
      default:
      begin
        next_dq_o = 4'h0;
        next_dq_oe = 4'h0;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state <= HS_IDLE;
      op <= QOP_READ;
      cnt <= 4'h0;
      div <= 4'h0;
      sclk <= 1'b0;
      cs_n <= 1'b1;
      sh <= 32'h0000_0000;
      dq_o <= 4'h0;
      dq_oe <= 4'h0;
      rx <= 8'h00;
      mode <= 8'h00;
      rd_data <= 8'h00;
      qpi <= QCRM_QPI_RST;
      cont <= QCRM_CONT_RST;
      qe <= QCRM_QE_RST;
      addr4 <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
      wdata <= 8'h00;
      addr <= 32'h0000_0000;
    end
    else
    begin
      state <= next_state;
      op <= next_op;
      cnt <= next_cnt;
      div <= next_div;
      sclk <= next_sclk;
      cs_n <= next_cs_n;
      sh <= next_sh;
      dq_o <= next_dq_o;
      dq_oe <= next_dq_oe;
      rx <= next_rx;
      mode <= next_mode;
      rd_data <= next_rd_data;
      qpi <= next_qpi;
      cont <= next_cont;
      qe <= next_qe;
      addr4 <= next_addr4;
      busy <= next_busy;
      done <= next_done;
      wdata <= next_wdata;
      addr <= next_addr;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign link.sclk = sclk;
  assign link.cs_n = cs_n;
  assign link.host_dq_o = dq_o;
  assign link.host_dq_oe = dq_oe;
  assign busy_o = busy;
  assign done_o = done;
  assign rd_data_o = rd_data;
  assign qpi_o = qpi;
  assign cont_rd_o = cont;
  assign quad_en_o = qe;

endmodule

`default_nettype wire

// ===== rtl/qcrm_pkg.sv
`default_nettype none

package qcrm_pkg;

  // ----------------------------------------------------------------------
  // Opcodes and mode byte values
  // ----------------------------------------------------------------------
  localparam logic [7:0] QCRM_OP_QREAD = 8'hEB;
  localparam logic [7:0] QCRM_OP_QPI_ON = 8'h35;
  localparam logic [7:0] QCRM_OP_QPI_OFF = 8'hF5;
  localparam logic [7:0] QCRM_OP_WRSR = 8'h01;
  localparam logic [7:0] QCRM_MODE_ENTER = 8'hA5;
  localparam logic [7:0] QCRM_MODE_EXIT = 8'h00;
  localparam logic [3:0] QCRM_MODE_KEEP_HI = 4'hA;
  localparam logic [3:0] QCRM_ALL_ONES = 4'hF;

  // ----------------------------------------------------------------------
  // Status register field and reset values
  // ----------------------------------------------------------------------
  localparam int unsigned QCRM_QE_POS = 6;
  localparam logic QCRM_QE_RST = 1'b0;
  localparam logic QCRM_QPI_RST = 1'b0;
  localparam logic QCRM_CONT_RST = 1'b0;

  // ----------------------------------------------------------------------
  // Serial clock counts per phase
  // ----------------------------------------------------------------------
  localparam logic [3:0] QCRM_SPI_BYTE_CLKS = 4'h8;
  localparam logic [3:0] QCRM_QPI_BYTE_CLKS = 4'h2;
  localparam logic [3:0] QCRM_ADDR3_CLKS = 4'h6;
  localparam logic [3:0] QCRM_ADDR4_CLKS = 4'h8;
  localparam logic [3:0] QCRM_MODE_CLKS = 4'h2;
  localparam logic [3:0] QCRM_DUMMY_CLKS = 4'h4;
  localparam logic [3:0] QCRM_DATA_CLKS = 4'h2;
  localparam logic [3:0] QCRM_EXIT3_CLKS = 4'h8;
  localparam logic [3:0] QCRM_EXIT4_CLKS = 4'hA;

  // Host serial clock half period in reference clock cycles.
  localparam logic [3:0] QCRM_SCLK_HALF = 4'h4;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    QOP_READ,
    QOP_QPI_ON,
    QOP_QPI_OFF,
    QOP_WRSR,
    QOP_MODE_RST
  } qcrm_op_t;

  typedef enum logic [2:0] {
    DS_IDLE, DS_OPC, DS_ADDR, DS_MODE, DS_DUMMY, DS_DATA, DS_WSR, DS_IGN
  } qcrm_dev_state_t;

  typedef enum logic [3:0] {
    HS_IDLE, HS_OPC, HS_ADDR, HS_MODE, HS_DUMMY, HS_DATA, HS_WDAT, HS_FF,
    HS_END
  } qcrm_host_state_t;

endpackage

`default_nettype wire

// ===== rtl/qcrm_link_if.sv
`default_nettype none

interface qcrm_link_if;
  logic sclk;
  logic cs_n;
  logic [3:0] host_dq_o;
  logic [3:0] host_dq_oe;
  logic [3:0] dev_dq_o;
  logic [3:0] dev_dq_oe;
  logic [3:0] dq;

  // Undriven lines float high through the board pull-ups.
  assign dq = (dev_dq_oe & dev_dq_o) | (host_dq_oe & host_dq_o) |
              ~(dev_dq_oe | host_dq_oe);

  modport dev (
    input sclk,
    input cs_n,
    input dq,
    output dev_dq_o,
    output dev_dq_oe
  );

  modport host (
    output sclk,
    output cs_n,
    output host_dq_o,
    output host_dq_oe,
    input dq
  );
endinterface

`default_nettype wire

// ===== rtl/qcrm_dev_end.sv
// Contract
// - Mode byte A5h enters continuous quad read.
// - Host sets quad enable before continuous read.
// - Mode byte 00h exits after current read.
// - Mode byte upper digit not A exits.
// - All-ones 8 or 10 clocks forces exit.
// - All-ones for 8 clocks clears continuous read; the code waits for 10 with 4-byte addresses.
// - Instruction 35h switches to four-line instructions.
// - Instruction F5h returns to single-line instructions.
// - Quad enable is status bit 6, one enables.
`default_nettype none

module qcrm_dev_end
  import qcrm_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Serial link
  qcrm_link_if.dev link,
  // User side
  input wire logic addr4_i,
  input wire logic [7:0] rd_data_i,
  output logic [31:0] rd_addr_o,
  output logic cont_rd_o,
  output logic qpi_o,
  output logic quad_en_o
);

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  // The clock and data lines share one synchroniser depth, so a sampled
  // edge always meets data that was stable around the pin edge.
  logic sclk_s1, sclk_s2, sclk_s3;
  logic cs_n_s1, cs_n_s2;
  logic [3:0] dq_s1, dq_s2;

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sclk_s1 <= 1'b0;
      sclk_s2 <= 1'b0;
      sclk_s3 <= 1'b0;
      cs_n_s1 <= 1'b1;
      cs_n_s2 <= 1'b1;
      dq_s1 <= 4'hF;
      dq_s2 <= 4'hF;
    end
    else
    begin
      sclk_s1 <= link.sclk;
      sclk_s2 <= sclk_s1;
      sclk_s3 <= sclk_s2;
      cs_n_s1 <= link.cs_n;
      cs_n_s2 <= cs_n_s1;
      dq_s1 <= link.dq;
      dq_s2 <= dq_s1;
    end
  end

  logic rise, fall, cs_act;
  assign rise = sclk_s2 & ~sclk_s3;
  assign fall = ~sclk_s2 & sclk_s3;
  assign cs_act = ~cs_n_s2;

  // ----------------------------------------------------------------------
  // Command decode and mode control
  // ----------------------------------------------------------------------
  qcrm_dev_state_t state, next_state;
  logic [3:0] cnt, next_cnt;
  logic [31:0] sh, next_sh;
  logic [3:0] ff_run, next_ff_run;
  logic ff_brk, next_ff_brk;
  logic quad_enable_bit, next_quad_enable_bit;
  logic qpi, next_qpi;
  logic cont_rd, next_cont_rd;
  logic pend_qpi, next_pend_qpi;
  logic pend_cont, next_pend_cont;
  logic [31:0] rd_addr, next_rd_addr;
  logic [3:0] dq_o, next_dq_o;
  logic [3:0] dq_oe, next_dq_oe;

  logic [31:0] shifted, quad_sh;
  logic [3:0] cnt_inc, addr_len, exit_len, byte_len;
  logic [7:0] mode_byte;

  always_comb
  begin
    next_state = state;
    next_cnt = cnt;
    next_sh = sh;
    next_ff_run = ff_run;
    next_ff_brk = ff_brk;
    next_quad_enable_bit = quad_enable_bit;
    next_qpi = qpi;
    next_cont_rd = cont_rd;
    next_pend_qpi = pend_qpi;
    next_pend_cont = pend_cont;
    next_rd_addr = rd_addr;
    next_dq_o = dq_o;
    next_dq_oe = dq_oe;
    shifted = qpi ? {sh[27:0], dq_s2} : {sh[30:0], dq_s2[0]};
    quad_sh = {sh[27:0], dq_s2};
    cnt_inc = cnt + 4'h1;
    addr_len = addr4_i ? QCRM_ADDR4_CLKS : QCRM_ADDR3_CLKS;
    exit_len = addr4_i ? QCRM_EXIT4_CLKS : QCRM_EXIT3_CLKS;
    byte_len = qpi ? QCRM_QPI_BYTE_CLKS : QCRM_SPI_BYTE_CLKS;
    mode_byte = quad_sh[7:0];
    if (!cs_act)
    begin
      // Deselection ends the frame; pending mode changes land here.
      if (state != DS_IDLE)
      begin
        next_qpi = pend_qpi;
        next_cont_rd = pend_cont;
      end
      next_state = DS_IDLE;
      next_dq_oe = 4'h0;
    end
    else if (state == DS_IDLE)
    begin
      next_cnt = 4'h0;
      next_sh = 32'h0000_0000;
      next_ff_run = 4'h0;
      next_ff_brk = 1'b0;
      next_pend_qpi = qpi;
      next_pend_cont = cont_rd;
      next_state = cont_rd ? DS_ADDR : DS_OPC;
    end
    else if (rise)
    begin
      next_cnt = cnt_inc;
      case (state)
        DS_OPC:
        begin
          next_sh = shifted;
          if (cnt_inc == byte_len)
          begin
            next_cnt = 4'h0;
            next_state = DS_IGN;
            if (shifted[7:0] == QCRM_OP_QREAD)
              next_state = DS_ADDR;
            else if (shifted[7:0] == QCRM_OP_WRSR)
              next_state = DS_WSR;
            else if (shifted[7:0] == QCRM_OP_QPI_ON && !qpi)
              next_pend_qpi = 1'b1;
            else if (shifted[7:0] == QCRM_OP_QPI_OFF && qpi)
              next_pend_qpi = 1'b0;
          end
        end
        DS_ADDR:
        begin
          next_sh = quad_sh;
          if (cnt_inc == addr_len)
          begin
            next_cnt = 4'h0;
            next_rd_addr = addr4_i ? quad_sh : {8'h00, quad_sh[23:0]};
            next_state = DS_MODE;
          end
        end
        DS_MODE:
        begin
          next_sh = quad_sh;
          if (cnt_inc == QCRM_MODE_CLKS)
          begin
            next_cnt = 4'h0;
            next_state = DS_DUMMY;
            // Without quad enable the entry byte is not honoured.
            if (mode_byte == QCRM_MODE_ENTER && quad_enable_bit)
              next_pend_cont = 1'b1;
            else if (mode_byte[7:4] != QCRM_MODE_KEEP_HI)
              next_pend_cont = 1'b0;
          end
        end
        DS_DUMMY:
        begin
          if (cnt_inc == QCRM_DUMMY_CLKS)
          begin
            next_cnt = 4'h0;
            next_state = DS_DATA;
          end
        end
        DS_WSR:
        begin
          next_sh = shifted;
          if (cnt_inc == byte_len)
          begin
            next_quad_enable_bit = shifted[QCRM_QE_POS];
            next_state = DS_IGN;
          end
        end
        DS_DATA:
        begin
          next_cnt = cnt;
        end
        default:
        begin
          next_cnt = cnt;
        end
      endcase
      // An all-ones run from the first address clock overrides the decode above.
      if (state == DS_ADDR || state == DS_MODE)
      begin
        next_ff_run = ff_run + 4'h1;
        if (dq_s2 != QCRM_ALL_ONES)
          next_ff_brk = 1'b1;
        else if (!ff_brk && (ff_run + 4'h1) == exit_len)
        begin
          next_pend_cont = 1'b0;
          next_state = DS_IGN;
        end
      end
    end
    else if (fall && state == DS_DATA)
    begin
      next_dq_oe = 4'hF;
      next_dq_o = cnt[0] ? rd_data_i[3:0] : rd_data_i[7:4];
      next_cnt = {cnt[3:1], ~cnt[0]};
      if (cnt[0])
        next_rd_addr = rd_addr + 32'h0000_0001;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state <= DS_IDLE;
      cnt <= 4'h0;
      sh <= 32'h0000_0000;
      ff_run <= 4'h0;
      ff_brk <= 1'b0;
      quad_enable_bit <= QCRM_QE_RST;
      qpi <= QCRM_QPI_RST;
      cont_rd <= QCRM_CONT_RST;
      pend_qpi <= QCRM_QPI_RST;
      pend_cont <= QCRM_CONT_RST;
      rd_addr <= 32'h0000_0000;
      dq_o <= 4'h0;
      dq_oe <= 4'h0;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
      sh <= next_sh;
      ff_run <= next_ff_run;
      ff_brk <= next_ff_brk;
      quad_enable_bit <= next_quad_enable_bit;
      qpi <= next_qpi;
      cont_rd <= next_cont_rd;
      pend_qpi <= next_pend_qpi;
      pend_cont <= next_pend_cont;
      rd_addr <= next_rd_addr;
      dq_o <= next_dq_o;
      dq_oe <= next_dq_oe;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign link.dev_dq_o = dq_o;
  assign link.dev_dq_oe = dq_oe;
  assign rd_addr_o = rd_addr;
  assign cont_rd_o = cont_rd;
  assign qpi_o = qpi;
  assign quad_en_o = quad_enable_bit;

endmodule

`default_nettype wire

// ===== dv/qcrm_link_monitor.sv
`default_nettype none

module qcrm_link_monitor
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Link signals
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic [3:0] host_dq_o,
  input wire logic [3:0] host_dq_oe,
  input wire logic [3:0] dev_dq_o,
  input wire logic [3:0] dev_dq_oe,
  input wire logic [3:0] dq
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------------
  // Serial clocks per frame
  // ----------------------------------------------------------------------
  logic [5:0] clk_cnt;
  logic [5:0] next_clk_cnt;
  logic sclk_q;
  logic next_sclk_q;

  always_comb
  begin
    next_sclk_q = sclk;
    next_clk_cnt = clk_cnt;
    if (cs_n)
      next_clk_cnt = 6'h00;
    else if (sclk && !sclk_q)
      next_clk_cnt = clk_cnt + 6'h01;
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      clk_cnt <= 6'h00;
      sclk_q <= 1'b0;
    end
    else
    begin
      clk_cnt <= next_clk_cnt;
      sclk_q <= next_sclk_q;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking mon_cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  // Only whole commands may close a frame; a short frame means a lost mode.
  a_frame_clocks: assert property ($rose(cs_n) |-> clk_cnt inside
    {6'h02, 6'h04, 6'h08, 6'h0A, 6'h0E, 6'h10, 6'h12, 6'h16, 6'h18})
    else $error("frame closed after an illegal clock count");
  a_sclk_idle_low: assert property (cs_n |-> !sclk)
    else $error("serial clock high outside a frame");
  a_no_contention: assert property ((host_dq_oe & dev_dq_oe) == 4'h0)
    else $error("both ends drive the same line");
  // The device sees deselection through its line synchronisers, so it may
  // keep driving for three cycles after the select line rises.
  a_dev_quiet_idle: assert property (cs_n && $past(cs_n, 3) |->
    dev_dq_oe == 4'h0)
    else $error("device drives while deselected");
  a_host_quiet_idle: assert property (cs_n |-> host_dq_oe == 4'h0)
    else $error("host drives while deselected");
  a_sclk_high_half: assert property ($rose(sclk) |-> sclk[*4] ##1 !sclk)
    else $error("serial clock high phase not four cycles");
  a_sclk_low_half: assert property ($fell(sclk) |-> (!sclk)[*4])
    else $error("serial clock low phase too short");
  a_frame_lead: assert property ($fell(cs_n) |-> (!sclk)[*4] ##1 sclk)
    else $error("first serial clock not four cycles after select");
  a_host_hold: assert property ($rose(sclk) |->
    ($stable({host_dq_oe, host_dq_o}))[*4])
    else $error("host lines moved while serial clock high");

  c_read_frame: cover property ($rose(cs_n) && clk_cnt == 6'h16);
  c_exit_four: cover property ($rose(cs_n) && clk_cnt == 6'h0A);
  c_dev_drive: cover property (dev_dq_oe != 4'h0);
endmodule

`default_nettype wire

// ===== dv/tb.sv
`default_nettype none

`define CHK(got, exp) \
  begin \
    num_checks++; \
    if ((got) !== (exp)) \
    begin \
      fails++; \
      $display("unexpected at %0t got %0h expected %0h", $time, got, exp); \
    end \
  end

module tb
  import qcrm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic ref_clk_i, rst_n_i, start, addr4, done, busy;
  qcrm_op_t op_c;
  logic [31:0] addr_c, rd_addr_d;
  logic [7:0] mode_c, wdata_c, rd_data_h, rd_data_d;
  logic qpi_h, cont_h, qe_h, qpi_d, cont_d, qe_d;
  int fails = 0;
  int num_checks = 0;

  qcrm_link_if link_bus();

  qcrm_dev_end i_qcrm_dev_end (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .link(link_bus), .addr4_i(addr4), .rd_data_i(rd_data_d),
    .rd_addr_o(rd_addr_d), .cont_rd_o(cont_d), .qpi_o(qpi_d),
    .quad_en_o(qe_d));

  qcrm_host_end i_qcrm_host_end (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .link(link_bus), .start_i(start), .op_i(op_c), .addr_i(addr_c),
    .mode_i(mode_c), .wdata_i(wdata_c), .addr4_i(addr4), .busy_o(busy),
    .done_o(done), .rd_data_o(rd_data_h), .qpi_o(qpi_h),
    .cont_rd_o(cont_h), .quad_en_o(qe_h));

  qcrm_link_monitor i_qcrm_link_monitor (.ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i), .sclk(link_bus.sclk), .cs_n(link_bus.cs_n),
    .host_dq_o(link_bus.host_dq_o), .host_dq_oe(link_bus.host_dq_oe),
    .dev_dq_o(link_bus.dev_dq_o), .dev_dq_oe(link_bus.dev_dq_oe),
    .dq(link_bus.dq));

  // Memory content is a plain function of the address, known to the bench.
  assign rd_data_d = rd_addr_d[7:0] ^ 8'h5A;

  initial
  begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // One command on the host port, then a settle time for the device's
  // two-flop line synchronisers to pass the frame end through.
  task automatic run(input qcrm_op_t op, input logic [31:0] a,
                     input logic [7:0] m, input logic [7:0] w);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    op_c <= op;
    addr_c <= a;
    mode_c <= m;
    wdata_c <= w;
    start <= 1'b1;
    @(posedge ref_clk_i);
    start <= 1'b0;
    #1;
    `CHK(busy, 1'b1)
    do
    begin
      @(posedge ref_clk_i);
      #1;
      n++;
    end
    while (done !== 1'b1 && n < 1000);
    if (n >= 1000)
    begin
      fails++;
      give_verdict();
    end
    `CHK(busy, 1'b0)
    repeat (4) @(posedge ref_clk_i);
    #1;
  endtask

  task automatic rd(input logic [31:0] a, input logic [7:0] m);
    run(QOP_READ, a, m, 8'h00);
    `CHK(rd_data_h, a[7:0] ^ 8'h5A)
  endtask

  task automatic st(input logic c, input logic q);
    `CHK(cont_d, c)
    `CHK(cont_h, c)
    `CHK(qpi_d, q)
    `CHK(qpi_h, q)
  endtask

  task automatic t_qe();
    st(1'b0, 1'b0);
    rd(32'h0000_0010, QCRM_MODE_ENTER);
    st(1'b0, 1'b0);
    run(QOP_WRSR, 32'h0, 8'h00, 8'hBF);
    `CHK(qe_d, 1'b0)
    run(QOP_WRSR, 32'h0, 8'h00, 8'h40);
    `CHK(qe_d, 1'b1)
    `CHK(qe_h, 1'b1)
    $display("t_qe finished");
  endtask

  task automatic t_cont();
    rd(32'h0000_0123, QCRM_MODE_ENTER);
    st(1'b1, 1'b0);
    rd(32'h0000_0456, 8'hA7);
    st(1'b1, 1'b0);
    rd(32'h0000_0789, QCRM_MODE_EXIT);
    st(1'b0, 1'b0);
    rd(32'h0000_0ABC, QCRM_MODE_ENTER);
    rd(32'h0000_0DEF, 8'h5A);
    st(1'b0, 1'b0);
    rd(32'h0000_0F01, QCRM_MODE_ENTER);
    rd(32'h0000_0F02, 8'hB5);
    st(1'b0, 1'b0);
    $display("t_cont finished");
  endtask

  task automatic t_exit();
    rd(32'h0000_0033, QCRM_MODE_ENTER);
    st(1'b1, 1'b0);
    run(QOP_MODE_RST, 32'h0, 8'h00, 8'h00);
    st(1'b0, 1'b0);
    rd(32'h0000_0034, 8'h00);
    @(posedge ref_clk_i);
    addr4 <= 1'b1;
    rd(32'h0102_0304, QCRM_MODE_ENTER);
    rd(32'h0102_03F7, QCRM_MODE_ENTER);
    st(1'b1, 1'b0);
    run(QOP_MODE_RST, 32'h0, 8'h00, 8'h00);
    st(1'b0, 1'b0);
    rd(32'h0A0B_0C0D, 8'h00);
    @(posedge ref_clk_i);
    addr4 <= 1'b0;
    $display("t_exit finished");
  endtask

  task automatic t_qpi();
    run(QOP_QPI_ON, 32'h0, 8'h00, 8'h00);
    st(1'b0, 1'b1);
    run(QOP_QPI_ON, 32'h0, 8'h00, 8'h00);
    st(1'b0, 1'b1);
    rd(32'h0000_0555, QCRM_MODE_ENTER);
    st(1'b1, 1'b1);
    rd(32'h0000_0556, QCRM_MODE_EXIT);
    st(1'b0, 1'b1);
    run(QOP_QPI_OFF, 32'h0, 8'h00, 8'h00);
    st(1'b0, 1'b0);
    run(QOP_QPI_OFF, 32'h0, 8'h00, 8'h00);
    st(1'b0, 1'b0);
    rd(32'h0000_0777, QCRM_MODE_EXIT);
    $display("t_qpi finished");
  endtask

  initial
  begin
    rst_n_i = 1'b0;
    start = 1'b0;
    addr4 = 1'b0;
    op_c = QOP_READ;
    addr_c = 32'h0;
    mode_c = 8'h00;
    wdata_c = 8'h00;
    repeat (12) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    #1;
    t_qe();
    t_cont();
    t_exit();
    t_qpi();
    give_verdict();
  end
endmodule

`default_nettype wire
